//--- prs_phase_gen.sv
`timescale 1ns/1ps
module prs_phase_gen (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Phase outputs
    prs_phase_if.gen pif
);
    logic div_q;
    prs_pkg::prs_phase_e phase_q;
    prs_pkg::prs_phase_e phase_d;

    // Halve the oscillator
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            div_q <= 1'b0;
        end else begin
            div_q <= ~div_q;
        end
    end

    // Next phase in Gray order
    always_comb begin
        case (phase_q)
            prs_pkg::PH_FETCH: phase_d = prs_pkg::PH_LATCH;
            prs_pkg::PH_LATCH: phase_d = prs_pkg::PH_WAVE;
            prs_pkg::PH_WAVE: phase_d = prs_pkg::PH_LAST;
            prs_pkg::PH_LAST: phase_d = prs_pkg::PH_FETCH;
            default: phase_d = prs_pkg::PH_FETCH;
        endcase
    end

    // Advance one phase per machine clock
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            phase_q <= prs_pkg::PH_FETCH;
        end else if (div_q) begin
            phase_q <= phase_d;
        end
    end

    // Strobes toward the sequencer
    assign pif.mclk = div_q;
    assign pif.tick = div_q;
    assign pif.phase = phase_q;
    assign pif.cyc_end = div_q && (phase_q == prs_pkg::PH_LAST);

    a_mclk_toggle: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $past(resetn_i) |-> div_q != $past(div_q))
        else $error("machine clock not halved");
endmodule

//--- prs_phase_if.sv
`timescale 1ns/1ps
interface prs_phase_if;
    logic mclk;
    logic tick;
    prs_pkg::prs_phase_e phase;
    logic cyc_end;
    modport gen (output mclk, output tick, output phase, output cyc_end);
    modport use_ (input mclk, input tick, input phase, input cyc_end);
endinterface

//--- prs_pkg.sv
// What this block does
// - Machine clock is oscillator divided by two
// - Four phases make one instruction cycle
// - Fetch next word while current one executes
// - Counter-changing instructions take two cycles
// - Thirteen-bit counter covers 8192 words per bank
// - Counter advances by one after each fetch
// - Transfers load the event's own target address
// - Taken skip discards prefetched word, dummy cycle
// - Low byte register at 06H; write jumps short
// - Every control transfer costs one dummy cycle
// - Sixteen ROM lines, program and wavetable types
// - Program address uses bank bits and counter
// - Timer 0 vector 008H, bank kept
// - Timer 1 vector 00CH, bank kept
// - Reset starts at address zero, bank zero
// - Program address is bank times 2^13 plus counter
// - Wave address is start shifted, low five zero
package prs_pkg;
    // Widths
    localparam int PC_W = 13;
    localparam int BANK_W = 2;
    localparam int ROM_AW = 16;
    localparam int WAVE_W = 11;
    localparam int WAVE_PAD = 5;
    localparam int INSTR_W = 16;
    // Machine clock division and phases per instruction cycle
    localparam int MCLK_DIV = 2;
    localparam int PHASES = 4;
    localparam int CYC_CLKS = MCLK_DIV * PHASES;
    // Register indices; byte address is four times the index
    localparam logic [5:0] REG_PCL_IDX = 6'h06;
    localparam logic [5:0] REG_BANK_IDX = 6'h1c;
    localparam logic [5:0] REG_STAT_IDX = 6'h20;
    // Vectors and reset values
    localparam logic [PC_W-1:0] VEC_RESET = 13'h0000;
    localparam logic [PC_W-1:0] VEC_TMR0 = 13'h0008;
    localparam logic [PC_W-1:0] VEC_TMR1 = 13'h000c;
    localparam logic [BANK_W-1:0] BANK_RESET = 2'h0;
    localparam logic [WAVE_PAD-1:0] WAVE_LOW = 5'h00;
    // Phase sequence, Gray coded
    typedef enum logic [1:0] {
        PH_FETCH = 2'b00,
        PH_LATCH = 2'b01,
        PH_WAVE = 2'b11,
        PH_LAST = 2'b10
    } prs_phase_e;
endpackage

//--- prs_rom_model.sv
`timescale 1ns/1ps
module prs_rom_model (
    // Clock
    input wire logic clk_i,
    // ROM side
    input wire logic [15:0] addr_i,
    output logic [15:0] data_o
);
    logic [15:0] seen_q;

    // Address held at the previous edge
    always_ff @(posedge clk_i) begin
        seen_q <= addr_i;
    end

    // Word contents; wrong data for one clock after an address change
    always_comb begin
        if (addr_i == seen_q) begin
            data_o = addr_i ^ 16'h5a3c;
        end else begin
            data_o = ~(addr_i ^ 16'h5a3c);
        end
    end
endmodule

//--- prs_sequencer.sv
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
module prs_sequencer (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RESETN_I,
    // Wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // Shared ROM
    output logic [15:0] ROM_ADDR_O,
    output logic ROM_WAVE_O,
    input wire logic [15:0] ROM_DATA_I,
    // Execute unit requests
    input wire logic JUMP_I,
    input wire logic CALL_I,
    input wire logic [12:0] TARGET_I,
    input wire logic RET_I,
    input wire logic [12:0] STACK_TOP_I,
    input wire logic SKIP_I,
    input wire logic TMR0_IRQ_I,
    input wire logic TMR1_IRQ_I,
    // Instruction toward the execute unit
    output logic [15:0] INSTR_O,
    output logic INSTR_VALID_O,
    output logic CYC_END_O,
    output logic MCLK_O,
    output logic PUSH_O,
    output logic [12:0] PUSH_ADDR_O,
    output logic [1:0] IRQ_ACK_O,
    // Wavetable reads
    input wire logic WAVE_REQ_I,
    input wire logic [10:0] WAVE_START_I,
    output logic [15:0] WAVE_DATA_O,
    output logic WAVE_ACK_O
);
    localparam int PC_W = prs_pkg::PC_W;
    localparam int BANK_W = prs_pkg::BANK_W;

    prs_phase_if pif ();

    logic [PC_W-1:0] pc_q;
    logic [BANK_W-1:0] bank_q;
    logic [BANK_W-1:0] bank_pend_q;
    logic [15:0] fetch_q;
    logic exec_valid_q;
    logic pcl_pend_q;
    logic [7:0] pcl_data_q;
    logic wave_pend_q;
    logic [prs_pkg::WAVE_W-1:0] wave_st_q;
    logic wave_rd_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic mclk_q;
    logic cyc_end_q;
    logic push_q;
    logic [PC_W-1:0] push_addr_q;
    logic [1:0] irq_ack_q;
    logic [15:0] wave_data_q;
    logic wave_ack_q;
    logic [15:0] rom_addr_q;
    logic rom_wave_q;

    logic fetch_tick;
    logic latch_tick;
    logic wave_tick;
    logic last_tick;
    logic do_jump;
    logic do_ret;
    logic do_skip;
    logic do_pcl;
    logic do_tmr0;
    logic do_tmr1;
    logic flush;
    logic bus_req;
    logic bus_wr;
    logic [5:0] bus_idx;

    // Program address: bank times 2^13 plus counter
    function automatic logic [15:0] prog_addr(
        input logic [BANK_W-1:0] bank,
        input logic [PC_W-1:0] pc
    );
        prog_addr = {1'b0, bank, pc};
    endfunction

    // Wave address: start on a 32-word boundary
    function automatic logic [15:0] wave_addr(
        input logic [prs_pkg::WAVE_W-1:0] st
    );
        wave_addr = {st, prs_pkg::WAVE_LOW};
    endfunction

    prs_phase_gen u_phase (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .pif(pif.gen)
    );

    // Phase strobes
    assign fetch_tick = pif.tick && (pif.phase == prs_pkg::PH_FETCH);
    assign latch_tick = pif.tick && (pif.phase == prs_pkg::PH_LATCH);
    assign wave_tick = pif.tick && (pif.phase == prs_pkg::PH_WAVE);
    assign last_tick = pif.cyc_end;

    // Transfer decisions at the end of an instruction cycle
    assign do_jump = last_tick && exec_valid_q && (JUMP_I || CALL_I);
    assign do_ret = last_tick && exec_valid_q && RET_I && !do_jump;
    assign do_skip = last_tick && exec_valid_q && SKIP_I
                     && !do_jump && !do_ret;
    assign do_pcl = last_tick && pcl_pend_q && !do_jump && !do_ret;
    assign do_tmr0 = last_tick && exec_valid_q && TMR0_IRQ_I
                     && !do_jump && !do_ret && !do_skip && !do_pcl;
    assign do_tmr1 = last_tick && exec_valid_q && TMR1_IRQ_I
                     && !TMR0_IRQ_I && !do_jump && !do_ret
                     && !do_skip && !do_pcl;
    assign flush = do_jump || do_ret || do_skip || do_pcl
                   || do_tmr0 || do_tmr1;

    // Bus decode
    assign bus_req = CYC_I && STB_I && !ack_q;
    // Writes land at the edge where the master sees the acknowledge
    assign bus_wr = CYC_I && STB_I && WE_I && ack_q;
    assign bus_idx = ADR_I[7:2];

    // Sequence counter
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            pc_q <= prs_pkg::VEC_RESET;
        end else if (do_jump) begin
            pc_q <= TARGET_I;
        end else if (do_ret) begin
            pc_q <= STACK_TOP_I;
        end else if (do_pcl) begin
            pc_q <= {pc_q[PC_W-1:8], pcl_data_q};
        end else if (do_tmr0) begin
            pc_q <= prs_pkg::VEC_TMR0;
        end else if (do_tmr1) begin
            pc_q <= prs_pkg::VEC_TMR1;
        end else if (latch_tick) begin
            pc_q <= pc_q + 13'h0001;
        end
    end

    // Bank select, taken at a cycle boundary
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            bank_q <= prs_pkg::BANK_RESET;
            bank_pend_q <= prs_pkg::BANK_RESET;
        end else begin
            if (bus_wr && bus_idx == prs_pkg::REG_BANK_IDX && SEL_I[0]) begin
                bank_pend_q <= DAT_I[BANK_W-1:0];
            end
            if (last_tick) begin
                bank_q <= bank_pend_q;
            end
        end
    end

    // Pending low byte write
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            pcl_pend_q <= 1'b0;
            pcl_data_q <= 8'h00;
        end else if (bus_wr && bus_idx == prs_pkg::REG_PCL_IDX
                     && SEL_I[0]) begin
            pcl_pend_q <= 1'b1;
            pcl_data_q <= DAT_I[7:0];
        end else if (do_pcl) begin
            pcl_pend_q <= 1'b0;
        end
    end

    // Two-stage pipeline
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            fetch_q <= 16'h0000;
            INSTR_O <= 16'h0000;
            exec_valid_q <= 1'b0;
        end else begin
            if (latch_tick) begin
                fetch_q <= ROM_DATA_I;
            end
            if (last_tick) begin
                INSTR_O <= fetch_q;
                exec_valid_q <= !flush;
            end
        end
    end

    // Wave request holding
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            wave_pend_q <= 1'b0;
            wave_st_q <= 11'h000;
        end else if (WAVE_REQ_I) begin
            wave_pend_q <= 1'b1;
            wave_st_q <= WAVE_START_I;
        end else if (wave_tick) begin
            wave_pend_q <= 1'b0;
        end
    end

    // ROM address lines, two address types
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            rom_addr_q <= 16'h0000;
            rom_wave_q <= 1'b0;
            wave_rd_q <= 1'b0;
        end else begin
            if (fetch_tick) begin
                rom_addr_q <= prog_addr(bank_q, pc_q);
                rom_wave_q <= 1'b0;
            end else if (wave_tick && wave_pend_q) begin
                rom_addr_q <= wave_addr(wave_st_q);
                rom_wave_q <= 1'b1;
            end
            if (wave_tick) begin
                wave_rd_q <= wave_pend_q;
            end else if (last_tick) begin
                wave_rd_q <= 1'b0;
            end
        end
    end

    // Wave data return
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            wave_data_q <= 16'h0000;
            wave_ack_q <= 1'b0;
        end else begin
            wave_ack_q <= last_tick && wave_rd_q;
            if (last_tick && wave_rd_q) begin
                wave_data_q <= ROM_DATA_I;
            end
        end
    end

    // Stack push and interrupt acknowledge
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            push_q <= 1'b0;
            push_addr_q <= 13'h0000;
            irq_ack_q <= 2'b00;
        end else begin
            push_q <= (do_jump && CALL_I) || do_tmr0 || do_tmr1;
            push_addr_q <= pc_q - 13'h0001;
            irq_ack_q <= {do_tmr1, do_tmr0};
        end
    end

    // Wishbone answer, one wait state
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req;
            dat_q <= 32'h0000_0000;
            if (bus_req && !WE_I) begin
                case (bus_idx)
                    prs_pkg::REG_PCL_IDX: dat_q <= {24'h0, pc_q[7:0]};
                    prs_pkg::REG_BANK_IDX: dat_q <= {30'h0, bank_q};
                    prs_pkg::REG_STAT_IDX:
                        dat_q <= {16'h0, exec_valid_q, bank_q, pc_q};
                    default: dat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Output registers
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            mclk_q <= 1'b0;
            cyc_end_q <= 1'b0;
        end else begin
            mclk_q <= pif.mclk;
            cyc_end_q <= last_tick;
        end
    end

    assign DAT_O = dat_q;
    assign ACK_O = ack_q;
    assign ROM_ADDR_O = rom_addr_q;
    assign ROM_WAVE_O = rom_wave_q;
    assign INSTR_VALID_O = exec_valid_q;
    assign CYC_END_O = cyc_end_q;
    assign MCLK_O = mclk_q;
    assign PUSH_O = push_q;
    assign PUSH_ADDR_O = push_addr_q;
    assign IRQ_ACK_O = irq_ack_q;
    assign WAVE_DATA_O = wave_data_q;
    assign WAVE_ACK_O = wave_ack_q;

    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    a_cycle_eight_clk: assert property (
        last_tick |=> !last_tick [*7] ##1 last_tick)
        else $error("instruction cycle not eight clocks");
    a_pc_increment: assert property (
        latch_tick |=> pc_q == $past(pc_q) + 13'h0001)
        else $error("counter did not advance by one");
    a_jump_target: assert property (
        do_jump |=> pc_q == $past(TARGET_I))
        else $error("jump target not loaded");
    a_transfer_dummy: assert property (
        flush |=> !exec_valid_q [*8])
        else $error("transfer without dummy cycle");
    a_skip_discard: assert property (
        do_skip |=> !exec_valid_q ##7 !exec_valid_q ##1 1'b1)
        else $error("skipped word not discarded");
    a_pcl_short_jump: assert property (
        do_pcl |=> pc_q[12:8] == $past(pc_q[12:8])
                   && pc_q[7:0] == $past(pcl_data_q)
                   && bank_q == $past(bank_pend_q))
        else $error("low byte write wrong");
    a_tmr0_vector: assert property (
        do_tmr0 |=> pc_q == 13'h0008 && PUSH_O)
        else $error("timer 0 vector wrong");
    a_tmr1_vector: assert property (
        do_tmr1 |=> pc_q == 13'h000c && IRQ_ACK_O == 2'b10)
        else $error("timer 1 vector wrong");
    a_prog_address: assert property (
        fetch_tick |=> ROM_ADDR_O == {1'b0, $past(bank_q), $past(pc_q)}
                       && !ROM_WAVE_O)
        else $error("program address wrong");
    a_wave_align: assert property (
        ROM_WAVE_O |-> ROM_ADDR_O[4:0] == 5'h00)
        else $error("wave address not aligned");
    a_pipe_handoff: assert property (
        last_tick |=> INSTR_O == $past(fetch_q))
        else $error("prefetched word not handed on");
    a_reset_start: assert property (
        $rose(RESETN_I) |-> pc_q == 13'h0000 && bank_q == 2'h0)
        else $error("reset start wrong");

    c_jump: cover property (do_jump ##[1:16] exec_valid_q);
    c_skip: cover property (do_skip);
    c_tmr0: cover property (do_tmr0);
    c_wave: cover property (WAVE_REQ_I ##[1:16] WAVE_ACK_O);
endmodule

//--- test_program_sequencer.sv
`timescale 1ns/1ps
module test_program_sequencer;
    logic clk, resetn, cyc, stb, we, ack, rom_wave, jump, call, ret, skip;
    logic tmr0, tmr1, valid, cyc_end, mclk, push, wave_req, wave_ack;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w, dat_r;
    logic [15:0] rom_addr, rom_data, instr, wave_data;
    logic [12:0] target, stack_top, push_addr, exp_pc;
    logic [10:0] wave_start;
    logic [1:0] irq_ack, bank;
    int n_errors = 0;
    int n_compared = 0;

    // Design and ROM partner
    prs_sequencer dut_u (
        .CLK_I(clk), .RESETN_I(resetn), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r),
        .ACK_O(ack), .ROM_ADDR_O(rom_addr), .ROM_WAVE_O(rom_wave),
        .ROM_DATA_I(rom_data), .JUMP_I(jump), .CALL_I(call),
        .TARGET_I(target), .RET_I(ret), .STACK_TOP_I(stack_top),
        .SKIP_I(skip), .TMR0_IRQ_I(tmr0), .TMR1_IRQ_I(tmr1),
        .INSTR_O(instr), .INSTR_VALID_O(valid), .CYC_END_O(cyc_end),
        .MCLK_O(mclk), .PUSH_O(push), .PUSH_ADDR_O(push_addr),
        .IRQ_ACK_O(irq_ack), .WAVE_REQ_I(wave_req),
        .WAVE_START_I(wave_start), .WAVE_DATA_O(wave_data),
        .WAVE_ACK_O(wave_ack)
    );
    prs_rom_model rom_u (.clk_i(clk), .addr_i(rom_addr), .data_o(rom_data));

    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Expected program word at a counter value
    function automatic logic [31:0] word(input logic [12:0] pc);
        return 32'({1'b0, bank, pc} ^ 16'h5a3c);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One classic Wishbone cycle
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [3:0] s, input logic [7:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat_w <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) n_errors++;
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    // Wait for the next instruction cycle boundary
    task automatic wait_end(output logic v, output logic [15:0] i);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (cyc_end !== 1'b1 && n < 40);
        if (n >= 40) n_errors++;
        v = valid;
        i = instr;
    endtask

    task automatic sync(output logic [15:0] i);
        logic v;
        int n;
        n = 0;
        do begin
            wait_end(v, i);
            n++;
        end while (v !== 1'b1 && n < 4);
    endtask

    task automatic step();
        logic v;
        logic [15:0] i;
        exp_pc = exp_pc + 13'h1;
        wait_end(v, i);
        check(32'(v), 32'h1);
        check(32'(i), word(exp_pc));
    endtask

    // Kinds: jump, call, return, low byte write, skip, timer 0, timer 1
    task automatic transfer(input int k);
        logic v;
        logic [15:0] i;
        logic [31:0] q;
        logic [12:0] t;
        case (k)
            0, 1: t = target;
            2: t = stack_top;
            3: t = {exp_pc[12:8], 8'h55};
            4: t = exp_pc + 13'h2;
            5: t = 13'h0008;
            default: t = 13'h000c;
        endcase
        jump <= (k == 0);
        call <= (k == 1);
        ret <= (k == 2);
        skip <= (k == 4);
        tmr0 <= (k == 5);
        tmr1 <= (k == 6);
        if (k == 3) wb(1'b1, 8'h18, 4'h1, 8'h55, q);
        wait_end(v, i);
        {jump, call, ret, skip, tmr0, tmr1} <= 6'h00;
        check(32'(v), 32'h0);
        check(32'(push), 32'(k == 1 || k >= 5));
        check(32'(irq_ack), (k == 5) ? 32'h1 : (k == 6) ? 32'h2 : 32'h0);
        if (k == 1 || k >= 5) check(32'(push_addr), 32'(exp_pc + 13'h1));
        wait_end(v, i);
        exp_pc = t;
        check(32'(v), 32'h1);
        check(32'(i), word(t));
    endtask

    // Main sequence
    initial begin
        logic [15:0] i;
        logic [31:0] q;
        logic m;
        int n;
        resetn = 1'b0;
        {cyc, stb, we, jump, call, ret, skip, tmr0, tmr1, wave_req} = 10'h000;
        adr = 8'h00;
        sel = 4'h0;
        dat_w = 32'h0;
        target = 13'h1234;
        stack_top = 13'h0a5b;
        wave_start = 11'h000;
        bank = 2'h0;
        exp_pc = 13'h0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        sync(i);
        check(32'(i), word(13'h0));
        step();
        step();
        wb(1'b0, 8'h18, 4'h1, 8'h00, q);
        check(q, 32'((exp_pc + 13'h1) & 13'h0ff));
        repeat (4) begin
            @(posedge clk);
            m = mclk;
            @(posedge clk);
            check(32'(mclk), 32'(!m));
        end
        wait_end(m, i);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (cyc_end !== 1'b1 && n < 20);
        check(32'(n), 32'd8);
        wb(1'b0, 8'h40, 4'h1, 8'h00, q);
        check(q, 32'h0);
        wb(1'b1, 8'h70, 4'h1, 8'h02, q);
        wb(1'b1, 8'h70, 4'h0, 8'h03, q);
        wb(1'b0, 8'h70, 4'h1, 8'h00, q);
        check(q, 32'h2);
        bank = 2'h2;
        wave_start <= 11'h5a3;
        wave_req <= 1'b1;
        @(posedge clk);
        wave_req <= 1'b0;
        n = 1;
        do begin
            @(posedge clk);
            n++;
            if (rom_wave === 1'b1) q = 32'(rom_addr);
        end while (wave_ack !== 1'b1 && n < 40);
        check(q, 32'hb460);
        check(32'(wave_data), 32'(16'hb460 ^ 16'h5a3c));
        check(32'(n <= 16), 32'h1);
        sync(i);
        for (int k = 0; k < 7; k++) begin
            transfer(k);
        end
        step();
        complete_run();
    end

    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule
